// ===== inc/eesc_pkg.sv
// constants and types for the enclave extended-state control block
package eesc_pkg;
  localparam int unsigned XW = 64;
  localparam logic [63:0] LEGACY_MASK = 64'h0000_0000_0000_0003;
  localparam int unsigned TOP_BIT = 63;
  localparam logic [15:0] SSM_INTR_OFFSET = 16'h7EE0;
  localparam int unsigned SSM_INTR_BIT = 1;
  localparam logic [2:0] OP_CREATE = 3'h1;
  localparam logic [2:0] OP_ENTER = 3'h2;
  localparam logic [2:0] OP_RESUME = 3'h3;
  localparam logic [2:0] OP_LEAVE = 3'h4;
  localparam logic [2:0] OP_REPORT = 3'h5;
  localparam logic [2:0] OP_KEY = 3'h6;
  typedef enum logic [1:0] {
    EESC_FLT_NONE,
    EESC_FLT_GP,
    EESC_FLT_UD
  } eesc_fault_type;
  typedef enum logic [2:0] {
    EESC_AEX_NONE,
    EESC_AEX_SMM,
    EESC_AEX_SMM_VMEXIT,
    EESC_AEX_INIT_FW,
    EESC_AEX_INIT_WAIT,
    EESC_AEX_VMEXIT,
    EESC_AEX_OTHER
  } eesc_aex_type;
endpackage

// ===== src/eesc_ctrl.sv
// enclave extended-state checks, control register swap and async exit handling
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// What this block does
// RULE1: create faults unless mask low bits 11
// RULE2: no extended save: upper bits, zero frame fault
// RULE3: extended save: illegal, bit63, small frame fault
// RULE4: enter faults on save enables or subset
// RULE5: resume uses the same checks as enter
// RULE6: enter hides control reg, loads mask
// RULE7: async exit saves state using mask, wide
// RULE8: saved bitmap zero where mask zero
// RULE9: async exit restores control reg, synthesizes state
// RULE10: resume faults on bad save area contents
// RULE11: resume swaps reg, restores, marks modified
// RULE12: leave: no checks, restores control reg
// RULE13: report carries mask and misc selection
// RULE14: key mixes masked mask and misc bits
// RULE15: enclave instructions in mgmt mode fault invalid
// RULE16: mgmt interrupt exits, sets save-map bit
// RULE17: dual monitor: exit plus vm exit flagged
// RULE18: reset message exits, power-on init
// RULE19: reset message blocked in root operation
// RULE20: reset message non-root: exit, flagged vm exit
// RULE21: startup message inside enclave discarded
// RULE22: after reset-startup sequence, in-enclave flag 0
module eesc_ctrl
  import eesc_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic op_valid,
  input wire logic [2:0] op_code,
  input wire logic op_wide,
  input wire logic [63:0] feature_request_mask,
  input wire logic [31:0] misc_state_select,
  input wire logic [31:0] save_frame_pages,
  input wire logic [31:0] required_frame_pages,
  input wire logic ctrl_write_would_fault,
  input wire logic [63:0] key_attr_mask,
  input wire logic [31:0] key_misc_mask,
  input wire logic ext_save_supported,
  input wire logic os_legacy_save_enable,
  input wire logic os_extended_save_enable,
  input wire logic system_mgmt_mode,
  input wire logic [63:0] frame_saved_state_bitmap,
  input wire logic frame_header_nonzero,
  input wire logic frame_ctrl_reserved_set,
  input wire logic [63:0] ctrl_reg_wdata,
  input wire logic ctrl_reg_we,
  input wire logic async_exit_req,
  input wire logic system_mgmt_interrupt,
  input wire logic dual_monitor,
  input wire logic reset_msg,
  input wire logic vmx_root,
  input wire logic vmx_nonroot,
  input wire logic boot_processor,
  input wire logic startup_ipi_message,
  output logic [63:0] extended_feature_control_reg,
  output logic in_enclave,
  output logic op_done,
  output eesc_fault_type op_fault,
  output logic save_valid,
  output logic save_wide,
  output logic [63:0] save_request_bitmap,
  output logic [63:0] saved_state_bitmap,
  output logic synth_valid,
  output logic [63:0] synth_bitmap,
  output logic restore_valid,
  output logic [63:0] restore_bitmap,
  output logic mark_all_modified,
  output eesc_aex_type aex_kind,
  output logic ssm_interrupt_bit,
  output logic exit_reason_encl_flag,
  output logic guest_intr_encl_flag,
  output logic wait_for_startup,
  output logic startup_accepted,
  output logic [63:0] report_mask,
  output logic [31:0] report_misc,
  output logic [95:0] key_material
);
  // ==========================================
  // fault checks
  logic [63:0] hidden_ctrl;
  logic create_bad;
  logic entry_bad;
  logic frame_bad;
  logic mode_ud;
  logic aex_any;
  logic init_aex;
  logic smi_aex;
  always_comb begin
    create_bad = (feature_request_mask[1:0] != LEGACY_MASK[1:0]); // [RULE1]
    if (!ext_save_supported) begin
      create_bad = create_bad || (feature_request_mask[63:2] != '0)
        || (save_frame_pages == '0); // [RULE2]
    end else begin
      create_bad = create_bad || ctrl_write_would_fault || feature_request_mask[TOP_BIT]
        || (save_frame_pages < required_frame_pages); // [RULE3]
    end
  end
  always_comb begin
    entry_bad = !os_legacy_save_enable; // [RULE4] [RULE5]
    if (ext_save_supported) begin
      entry_bad = entry_bad
        || (!os_extended_save_enable && feature_request_mask != LEGACY_MASK)
        || ((feature_request_mask & extended_feature_control_reg) != feature_request_mask);
    end
    frame_bad = ((frame_saved_state_bitmap & ~feature_request_mask) != '0)
      || frame_header_nonzero || frame_ctrl_reserved_set; // [RULE10]
  end
  assign mode_ud = system_mgmt_mode; // [RULE15]
  assign smi_aex = in_enclave && system_mgmt_interrupt;
  assign init_aex = in_enclave && reset_msg && !vmx_root; // [RULE19]
  assign aex_any = in_enclave && (async_exit_req || smi_aex || init_aex);
  // ==========================================
  // operation results
  always_ff @(posedge core_clk) begin
    if (srst) begin
      op_done <= 1'b0;
      op_fault <= EESC_FLT_NONE;
    end else begin
      op_done <= op_valid;
      op_fault <= EESC_FLT_NONE;
      if (op_valid) begin
        if (mode_ud) begin
          op_fault <= EESC_FLT_UD; // [RULE15]
        end else if (op_code == OP_CREATE && create_bad) begin
          op_fault <= EESC_FLT_GP;
        end else if (op_code == OP_ENTER && entry_bad) begin
          op_fault <= EESC_FLT_GP;
        end else if (op_code == OP_RESUME && (entry_bad || frame_bad)) begin
          op_fault <= EESC_FLT_GP;
        end
      end
    end
  end
  logic op_ok;
  assign op_ok = op_valid && !mode_ud && !aex_any;
  // ==========================================
  // control register swap and enclave mode
  always_ff @(posedge core_clk) begin
    if (srst) begin
      extended_feature_control_reg <= LEGACY_MASK;
      hidden_ctrl <= LEGACY_MASK;
      in_enclave <= 1'b0;
    end else if (aex_any) begin
      extended_feature_control_reg <= hidden_ctrl; // [RULE9]
      in_enclave <= 1'b0; // [RULE22]
    end else if (op_ok && !in_enclave && ((op_code == OP_ENTER && !entry_bad)
        || (op_code == OP_RESUME && !entry_bad && !frame_bad))) begin
      hidden_ctrl <= extended_feature_control_reg; // [RULE6] [RULE11]
      extended_feature_control_reg <= feature_request_mask;
      in_enclave <= 1'b1;
    end else if (op_ok && in_enclave && op_code == OP_LEAVE) begin
      extended_feature_control_reg <= hidden_ctrl; // [RULE12]
      in_enclave <= 1'b0;
    end else if (ctrl_reg_we && !in_enclave) begin
      extended_feature_control_reg <= ctrl_reg_wdata;
    end
  end
  // ==========================================
  // save, synthesis and restore strobes
  always_ff @(posedge core_clk) begin
    if (srst) begin
      save_valid <= 1'b0;
      save_wide <= 1'b0;
      save_request_bitmap <= '0;
      saved_state_bitmap <= '0;
      synth_valid <= 1'b0;
      synth_bitmap <= '0;
    end else begin
      save_valid <= aex_any; // [RULE7]
      synth_valid <= aex_any; // [RULE9]
      if (aex_any) begin
        save_wide <= op_wide;
        save_request_bitmap <= feature_request_mask;
        saved_state_bitmap <= feature_request_mask & extended_feature_control_reg; // [RULE8]
        synth_bitmap <= feature_request_mask;
      end
    end
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      restore_valid <= 1'b0;
      restore_bitmap <= '0;
      mark_all_modified <= 1'b0;
    end else begin
      restore_valid <= 1'b0;
      mark_all_modified <= 1'b0;
      if (op_ok && !in_enclave && op_code == OP_RESUME && !entry_bad && !frame_bad) begin
        restore_valid <= 1'b1; // [RULE11]
        restore_bitmap <= feature_request_mask;
        mark_all_modified <= 1'b1;
      end
    end
  end
  // ==========================================
  // exit kinds and side flags
  always_ff @(posedge core_clk) begin
    if (srst) begin
      aex_kind <= EESC_AEX_NONE;
      ssm_interrupt_bit <= 1'b0;
      exit_reason_encl_flag <= 1'b0;
      guest_intr_encl_flag <= 1'b0;
      wait_for_startup <= 1'b0;
      startup_accepted <= 1'b0;
    end else begin
      aex_kind <= EESC_AEX_NONE;
      exit_reason_encl_flag <= 1'b0;
      guest_intr_encl_flag <= 1'b0;
      startup_accepted <= 1'b0;
      if (smi_aex && !dual_monitor) begin
        aex_kind <= EESC_AEX_SMM;
        ssm_interrupt_bit <= 1'b1; // [RULE16]
      end else if (smi_aex) begin
        aex_kind <= EESC_AEX_SMM_VMEXIT; // [RULE17]
        exit_reason_encl_flag <= 1'b1;
        guest_intr_encl_flag <= 1'b1;
      end else if (init_aex && vmx_nonroot) begin
        aex_kind <= EESC_AEX_VMEXIT; // [RULE20]
        exit_reason_encl_flag <= 1'b1;
      end else if (init_aex) begin
        aex_kind <= boot_processor ? EESC_AEX_INIT_FW : EESC_AEX_INIT_WAIT; // [RULE18]
        wait_for_startup <= !boot_processor;
      end else if (aex_any) begin
        aex_kind <= EESC_AEX_OTHER;
      end else if (!in_enclave && reset_msg && !vmx_root && !vmx_nonroot) begin
        wait_for_startup <= !boot_processor;
      end else if (startup_ipi_message && !in_enclave && wait_for_startup) begin
        wait_for_startup <= 1'b0; // [RULE21]
        startup_accepted <= 1'b1;
      end
      if (!system_mgmt_mode && !smi_aex) begin
        ssm_interrupt_bit <= 1'b0;
      end
    end
  end
  // ==========================================
  // report and key material
  always_ff @(posedge core_clk) begin
    if (srst) begin
      report_mask <= '0;
      report_misc <= '0;
      key_material <= '0;
    end else if (op_ok && in_enclave) begin
      if (op_code == OP_REPORT) begin
        report_mask <= feature_request_mask; // [RULE13]
        report_misc <= misc_state_select;
      end
      if (op_code == OP_KEY) begin
        key_material <= {feature_request_mask & key_attr_mask,
          misc_state_select & key_misc_mask}; // [RULE14]
      end
    end
  end
  // ==========================================
  // checks
  a_create_low_bits: assert property (@(posedge core_clk) disable iff (srst)
    op_valid && !mode_ud && op_code == OP_CREATE && feature_request_mask[1:0] != 2'b11
    |=> op_fault == EESC_FLT_GP) else $error("create low bits not faulted"); // [RULE1]
  a_create_no_xs: assert property (@(posedge core_clk) disable iff (srst)
    op_valid && !mode_ud && op_code == OP_CREATE && !ext_save_supported
    && save_frame_pages == '0 |=> op_fault == EESC_FLT_GP)
    else $error("zero frame not faulted"); // [RULE2]
  a_create_top_bit: assert property (@(posedge core_clk) disable iff (srst)
    op_valid && !mode_ud && op_code == OP_CREATE && ext_save_supported
    && feature_request_mask[63] |=> op_fault == EESC_FLT_GP)
    else $error("bit 63 not faulted"); // [RULE3]
  a_enter_legacy: assert property (@(posedge core_clk) disable iff (srst)
    op_valid && !mode_ud && op_code == OP_ENTER && !os_legacy_save_enable
    |=> op_fault == EESC_FLT_GP) else $error("enter legacy not faulted"); // [RULE4]
  a_resume_frame: assert property (@(posedge core_clk) disable iff (srst)
    op_valid && !mode_ud && op_code == OP_RESUME && frame_header_nonzero
    |=> op_fault == EESC_FLT_GP) else $error("bad frame not faulted"); // [RULE10]
  a_enter_swap: assert property (@(posedge core_clk) disable iff (srst)
    op_ok && !in_enclave && op_code == OP_ENTER && !entry_bad
    |=> in_enclave && extended_feature_control_reg == $past(feature_request_mask)
    && hidden_ctrl == $past(extended_feature_control_reg))
    else $error("enter swap wrong"); // [RULE6]
  a_aex_restore: assert property (@(posedge core_clk) disable iff (srst)
    aex_any |=> !in_enclave && extended_feature_control_reg == $past(hidden_ctrl)
    && save_valid && synth_valid) else $error("exit restore wrong"); // [RULE9]
  a_saved_bitmap: assert property (@(posedge core_clk) disable iff (srst)
    save_valid |-> (saved_state_bitmap & ~save_request_bitmap) == '0)
    else $error("saved bitmap outside mask"); // [RULE8]
  a_mgmt_ud: assert property (@(posedge core_clk) disable iff (srst)
    op_valid && system_mgmt_mode |=> op_fault == EESC_FLT_UD)
    else $error("mgmt mode not invalid"); // [RULE15]
  a_init_root: assert property (@(posedge core_clk) disable iff (srst)
    in_enclave && reset_msg && vmx_root && !system_mgmt_interrupt && !async_exit_req
    |=> in_enclave || $past(op_valid)) else $error("root reset not blocked"); // [RULE19]
  c_enter: cover property (@(posedge core_clk) op_ok && op_code == OP_ENTER && !entry_bad);
  c_aex_smm: cover property (@(posedge core_clk) aex_kind == EESC_AEX_SMM);
  c_resume: cover property (@(posedge core_clk) restore_valid);
endmodule
`default_nettype wire

// ===== tb/eesc_ctrl_bench.sv
// bench for the enclave extended-state control block
`timescale 1ns/100ps
`default_nettype none
module eesc_ctrl_bench
  import eesc_pkg::*;
;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic op_valid, op_wide, ctrl_write_would_fault, ext_save_supported;
  logic os_legacy_save_enable, os_extended_save_enable, system_mgmt_mode;
  logic frame_header_nonzero, frame_ctrl_reserved_set, dual_monitor;
  logic vmx_root, vmx_nonroot, boot_processor;
  logic [2:0] op_code;
  logic [4:0] ev;
  logic [63:0] feature_request_mask, key_attr_mask, frame_saved_state_bitmap, ctrl_reg_wdata;
  logic [31:0] misc_state_select, save_frame_pages, required_frame_pages, key_misc_mask;
  wire logic async_exit_req = ev[0];
  wire logic system_mgmt_interrupt = ev[1];
  wire logic reset_msg = ev[2];
  wire logic startup_ipi_message = ev[3];
  wire logic ctrl_reg_we = ev[4];
  logic [63:0] extended_feature_control_reg, save_request_bitmap, saved_state_bitmap;
  logic [63:0] synth_bitmap, restore_bitmap, report_mask;
  logic [31:0] report_misc;
  logic [95:0] key_material;
  logic in_enclave, op_done, save_valid, save_wide, synth_valid, restore_valid;
  logic mark_all_modified, ssm_interrupt_bit, exit_reason_encl_flag, guest_intr_encl_flag;
  logic wait_for_startup, startup_accepted;
  eesc_fault_type op_fault;
  eesc_aex_type aex_kind;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  eesc_ctrl u_dut (
    .core_clk(core_clk),
    .srst(srst),
    .op_valid(op_valid),
    .op_code(op_code),
    .op_wide(op_wide),
    .feature_request_mask(feature_request_mask),
    .misc_state_select(misc_state_select),
    .save_frame_pages(save_frame_pages),
    .required_frame_pages(required_frame_pages),
    .ctrl_write_would_fault(ctrl_write_would_fault),
    .key_attr_mask(key_attr_mask),
    .key_misc_mask(key_misc_mask),
    .ext_save_supported(ext_save_supported),
    .os_legacy_save_enable(os_legacy_save_enable),
    .os_extended_save_enable(os_extended_save_enable),
    .system_mgmt_mode(system_mgmt_mode),
    .frame_saved_state_bitmap(frame_saved_state_bitmap),
    .frame_header_nonzero(frame_header_nonzero),
    .frame_ctrl_reserved_set(frame_ctrl_reserved_set),
    .ctrl_reg_wdata(ctrl_reg_wdata),
    .ctrl_reg_we(ctrl_reg_we),
    .async_exit_req(async_exit_req),
    .system_mgmt_interrupt(system_mgmt_interrupt),
    .dual_monitor(dual_monitor),
    .reset_msg(reset_msg),
    .vmx_root(vmx_root),
    .vmx_nonroot(vmx_nonroot),
    .boot_processor(boot_processor),
    .startup_ipi_message(startup_ipi_message),
    .extended_feature_control_reg(extended_feature_control_reg),
    .in_enclave(in_enclave),
    .op_done(op_done),
    .op_fault(op_fault),
    .save_valid(save_valid),
    .save_wide(save_wide),
    .save_request_bitmap(save_request_bitmap),
    .saved_state_bitmap(saved_state_bitmap),
    .synth_valid(synth_valid),
    .synth_bitmap(synth_bitmap),
    .restore_valid(restore_valid),
    .restore_bitmap(restore_bitmap),
    .mark_all_modified(mark_all_modified),
    .aex_kind(aex_kind),
    .ssm_interrupt_bit(ssm_interrupt_bit),
    .exit_reason_encl_flag(exit_reason_encl_flag),
    .guest_intr_encl_flag(guest_intr_encl_flag),
    .wait_for_startup(wait_for_startup),
    .startup_accepted(startup_accepted),
    .report_mask(report_mask),
    .report_misc(report_misc),
    .key_material(key_material)
  );
  eesc_sw_model u_sw (.core_clk(core_clk), .op_valid(op_valid), .op_code(op_code));
  always #10 core_clk = ~core_clk;
  // ==========================================
  // helpers
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 1000) begin
      bad_count++;
      report_and_stop;
    end
  end
  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick;
    @(posedge core_clk);
    #1;
  endtask
  task automatic fire(input int i);
    ev[i] = 1'b1;
    tick;
    ev = '0;
  endtask
  task automatic op(input logic [2:0] code, input eesc_fault_type f);
    u_sw.issue(code);
    chk(op_done, 1'b1);
    chk(op_fault, f);
  endtask
  // ==========================================
  // tests
  initial begin
    {op_wide, ctrl_write_would_fault, ext_save_supported, os_legacy_save_enable} = '0;
    {os_extended_save_enable, system_mgmt_mode, frame_header_nonzero} = '0;
    {frame_ctrl_reserved_set, dual_monitor, vmx_root, vmx_nonroot, boot_processor} = '0;
    ev = '0;
    feature_request_mask = 64'h1;
    misc_state_select = 32'h0000_00A5;
    save_frame_pages = 32'h1;
    required_frame_pages = 32'h1;
    key_attr_mask = 64'h5;
    key_misc_mask = 32'h0000_00F0;
    frame_saved_state_bitmap = 64'h7;
    ctrl_reg_wdata = 64'hF;
    repeat (16) @(posedge core_clk);
    #1;
    srst = 1'b0;
    chk(extended_feature_control_reg, 64'h3);
    os_legacy_save_enable = 1'b1;
    op(OP_CREATE, EESC_FLT_GP);
    feature_request_mask = 64'h7;
    op(OP_CREATE, EESC_FLT_GP);
    feature_request_mask = 64'h3;
    save_frame_pages = 32'h0;
    op(OP_CREATE, EESC_FLT_GP);
    save_frame_pages = 32'h1;
    op(OP_CREATE, EESC_FLT_NONE);
    ext_save_supported = 1'b1;
    feature_request_mask = 64'h8000_0000_0000_0003;
    op(OP_CREATE, EESC_FLT_GP);
    feature_request_mask = 64'h7;
    ctrl_write_would_fault = 1'b1;
    op(OP_CREATE, EESC_FLT_GP);
    ctrl_write_would_fault = 1'b0;
    required_frame_pages = 32'h2;
    op(OP_CREATE, EESC_FLT_GP);
    required_frame_pages = 32'h1;
    op(OP_CREATE, EESC_FLT_NONE);
    $display("test create done");
    os_legacy_save_enable = 1'b0;
    op(OP_ENTER, EESC_FLT_GP);
    os_legacy_save_enable = 1'b1;
    op(OP_ENTER, EESC_FLT_GP);
    os_extended_save_enable = 1'b1;
    op(OP_ENTER, EESC_FLT_GP);
    fire(4);
    op(OP_ENTER, EESC_FLT_NONE);
    chk(extended_feature_control_reg, 64'h7);
    op_wide = 1'b1;
    fire(0);
    chk(save_valid & save_wide & synth_valid, 1'b1);
    chk(save_request_bitmap, 64'h7);
    chk(saved_state_bitmap & ~feature_request_mask, 64'h0);
    chk(saved_state_bitmap, 64'h7);
    chk(synth_bitmap, 64'h7);
    chk(extended_feature_control_reg, 64'hF);
    $display("test enter and exit done");
    frame_saved_state_bitmap = 64'hF;
    op(OP_RESUME, EESC_FLT_GP);
    frame_saved_state_bitmap = 64'h7;
    frame_header_nonzero = 1'b1;
    op(OP_RESUME, EESC_FLT_GP);
    frame_header_nonzero = 1'b0;
    frame_ctrl_reserved_set = 1'b1;
    op(OP_RESUME, EESC_FLT_GP);
    frame_ctrl_reserved_set = 1'b0;
    os_legacy_save_enable = 1'b0;
    op(OP_RESUME, EESC_FLT_GP);
    os_legacy_save_enable = 1'b1;
    op(OP_RESUME, EESC_FLT_NONE);
    chk(restore_valid & mark_all_modified, 1'b1);
    chk(restore_bitmap, 64'h7);
    chk(extended_feature_control_reg, 64'h7);
    op(OP_REPORT, EESC_FLT_NONE);
    chk({report_mask, report_misc}, {64'h7, 32'h0000_00A5});
    op(OP_KEY, EESC_FLT_NONE);
    chk(key_material, {64'h5, 32'h0000_00A0});
    os_legacy_save_enable = 1'b0;
    op(OP_LEAVE, EESC_FLT_NONE);
    chk(extended_feature_control_reg, 64'hF);
    os_legacy_save_enable = 1'b1;
    $display("test resume and leave done");
    system_mgmt_mode = 1'b1;
    for (int c = 1; c < 7; c++) op(3'(c), EESC_FLT_UD);
    system_mgmt_mode = 1'b0;
    op(OP_ENTER, EESC_FLT_NONE);
    system_mgmt_mode = 1'b1;
    fire(1);
    chk(aex_kind, EESC_AEX_SMM);
    chk(ssm_interrupt_bit, 1'b1);
    system_mgmt_mode = 1'b0;
    op(OP_ENTER, EESC_FLT_NONE);
    dual_monitor = 1'b1;
    fire(1);
    chk(aex_kind, EESC_AEX_SMM_VMEXIT);
    chk(exit_reason_encl_flag & guest_intr_encl_flag, 1'b1);
    dual_monitor = 1'b0;
    $display("test management interrupt done");
    op(OP_ENTER, EESC_FLT_NONE);
    vmx_root = 1'b1;
    fire(2);
    chk({in_enclave, aex_kind}, {1'b1, EESC_AEX_NONE});
    vmx_root = 1'b0;
    vmx_nonroot = 1'b1;
    tick;
    fire(2);
    chk(aex_kind, EESC_AEX_VMEXIT);
    chk(exit_reason_encl_flag, 1'b1);
    vmx_nonroot = 1'b0;
    op(OP_ENTER, EESC_FLT_NONE);
    fire(3);
    chk({startup_accepted, in_enclave}, 2'b01);
    tick;
    fire(2);
    chk(aex_kind, EESC_AEX_INIT_WAIT);
    chk(wait_for_startup, 1'b1);
    tick;
    fire(3);
    chk({startup_accepted, in_enclave}, 2'b10);
    $display("test reset messages done");
    report_and_stop;
  end
endmodule
`default_nettype wire

// ===== tb/eesc_sw_model.sv
// software-side model that issues enclave instructions
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// instruction issue
module eesc_sw_model
  import eesc_pkg::*;
(
  input wire logic core_clk,
  output logic op_valid,
  output logic [2:0] op_code
);
  initial begin
    op_valid = 1'b0;
    op_code = 3'h0;
  end
  // request held up to the taking edge, then dropped
  task automatic issue(input logic [2:0] code);
    @(posedge core_clk);
    #1;
    op_valid = 1'b1;
    op_code = code;
    @(posedge core_clk);
    #1;
    op_valid = 1'b0;
    op_code = ~code;
  endtask
endmodule
`default_nettype wire
